// ### hdl/bthl_loop_ctl.sv
`timescale 1ns/1ps
`include "bthl_regs.svh"

module bthl_loop_ctl (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWriteData,
  output logic      [31:0]          avsReadData,
  output logic                      avsWaitRequest,
  // Decoded operation from the sequencer
  input  wire logic                 opValid,
  input  wire bthl_pkg::bthl_op_req_t opReq,
  output logic                      opReady,
  output logic                      opDone,
  output logic                      opReject,
  output logic                      moveDropped,
  // Fetch address watch
  input  wire logic                 fetchValid,
  input  wire logic [15:0]          fetchAddress,
  output logic                      loopRedirect,
  output logic      [15:0]          redirectAddress,
  output logic                      loopExit,
  output logic                      loopActive,
  // Memory write-back of bit ops
  output logic                      bitWriteEnable,
  output logic      [15:0]          bitWriteData,
  // Flags, execution and system control
  output logic      [7:0]           conditionFlagReg,
  output logic                      execStrobe,
  output logic                      repeatHold,
  input  wire logic                 irqPending,
  output logic                      standbyWait,
  output logic                      standbyStop,
  output logic                      periphReset
);

  bthl_pkg::bthl_state_t state;
  bthl_pkg::bthl_state_t next_state;
  bthl_pkg::bthl_op_t    kind;

  logic [15:0] loopEndAddress;
  logic [15:0] loopIterationCount;
  logic [15:0] loopBodyAddress;
  logic        loopForever;
  logic [15:0] pendEnd;
  logic [15:0] pendCount;
  logic [15:0] pendBody;
  logic        pendForever;
  logic [15:0] repeatLeft;
  logic        rejectMode;
  logic        takeOp, doOp, rejectOp, parViolation;
  logic        isBitOp, isLoopOp, isProgOp, isStateOp;
  logic        endHit, endFinal, breakHit, abortHit, exitStart, startLoop;
  logic        stackPush, stackPop, testedBit, flagSwWrite, ctrlSwWrite;
  logic [15:0] bitMask, bitResult;
  logic [31:0] stackIn, stackTop, readMux;
  logic [4:0]  stackDepth;

  // Operation class decode
  assign kind      = opReq.kind;
  assign takeOp    = opValid && opReady;
  assign isBitOp   = (kind == bthl_pkg::OPK_BIT_TEST_INVERT_OP) ||
                     (kind == bthl_pkg::OPK_BIT_TEST_ZERO_OP) ||
                     (kind == bthl_pkg::OPK_BIT_TEST_ONE_OP) ||
                     (kind == bthl_pkg::OPK_BIT_TEST_ONLY_OP);
  assign isLoopOp  = (kind == bthl_pkg::OPK_LOOP_START_OP) ||
                     (kind == bthl_pkg::OPK_LOOP_FOREVER_OP) ||
                     (kind == bthl_pkg::OPK_COND_LOOP_BREAK_OP) ||
                     (kind == bthl_pkg::OPK_LOOP_ABORT_OP);
  assign isProgOp  = (kind == bthl_pkg::OPK_REPEAT_NEXT_OP) ||
                     (kind == bthl_pkg::OPK_WAIT_OP) ||
                     (kind == bthl_pkg::OPK_STOP_OP) ||
                     (kind == bthl_pkg::OPK_PERIPH_RESET_OP) ||
                     (kind == bthl_pkg::OPK_FLOW_OP);
  assign isStateOp = isLoopOp || (kind == bthl_pkg::OPK_WAIT_OP) ||
                     (kind == bthl_pkg::OPK_STOP_OP);

  assign parViolation = takeOp && (isBitOp || isLoopOp || isProgOp) && opReq.parallelMove;

  // Loop end detection on the fetch stream
  assign endHit   = (state == bthl_pkg::ST_IDLE) && loopActive && fetchValid &&
                    (fetchAddress == loopEndAddress);
  // final pass only for counted loops
  assign endFinal = endHit && !loopForever && (loopIterationCount == 16'h0001);

  // Refusals: parallel move, stack room, no loop to leave, end exit collision
  always_comb begin
    rejectOp = 1'b0;
    if (takeOp) begin
      if (parViolation && rejectMode) begin
        rejectOp = 1'b1;
      end else if (((kind == bthl_pkg::OPK_LOOP_START_OP) ||
                    (kind == bthl_pkg::OPK_LOOP_FOREVER_OP)) &&
                   (stackDepth > `BTHL_STACK_ROOM)) begin
        rejectOp = 1'b1;
      end else if (((kind == bthl_pkg::OPK_COND_LOOP_BREAK_OP) ||
                    (kind == bthl_pkg::OPK_LOOP_ABORT_OP)) && !loopActive) begin
        rejectOp = 1'b1;
      end else if (endFinal && isStateOp) begin
        rejectOp = 1'b1;
      end
    end
  end
  assign doOp = takeOp && !rejectOp;

  // break only on a true condition
  assign breakHit  = doOp && (kind == bthl_pkg::OPK_COND_LOOP_BREAK_OP) && opReq.condTrue;
  assign abortHit  = doOp && (kind == bthl_pkg::OPK_LOOP_ABORT_OP);
  assign exitStart = endFinal || breakHit || abortHit;
  assign startLoop = doOp && ((kind == bthl_pkg::OPK_LOOP_START_OP) ||
                              (kind == bthl_pkg::OPK_LOOP_FOREVER_OP));

  // context word first, then end address and count
  assign stackPush = ((state == bthl_pkg::ST_IDLE) && startLoop) ||
                     (state == bthl_pkg::ST_PUSH_LOOP);
  assign stackPop  = ((state == bthl_pkg::ST_IDLE) && exitStart) ||
                     (state == bthl_pkg::ST_POP_CTX);
  assign stackIn   = (state == bthl_pkg::ST_PUSH_LOOP) ? {loopEndAddress, loopIterationCount} :
                     {loopBodyAddress, 14'h0000, loopForever, loopActive};

  bthl_sys_stack u_stack (
    .clk      (clk),
    .rst_b    (rst_b),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (stackIn),
    .topData  (stackTop),
    .depth    (stackDepth)
  );

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      bthl_pkg::ST_IDLE: begin
        if (exitStart) begin
          next_state = bthl_pkg::ST_POP_CTX;
        end else if (startLoop) begin
          next_state = bthl_pkg::ST_PUSH_LOOP;
        end else if (doOp && (kind == bthl_pkg::OPK_WAIT_OP)) begin
          next_state = bthl_pkg::ST_WAIT;
        end else if (doOp && (kind == bthl_pkg::OPK_STOP_OP)) begin
          next_state = bthl_pkg::ST_STOP;
        end
      end
      bthl_pkg::ST_PUSH_LOOP: next_state = bthl_pkg::ST_IDLE;
      bthl_pkg::ST_POP_CTX:   next_state = bthl_pkg::ST_IDLE;
      bthl_pkg::ST_WAIT: begin
        if (irqPending) begin
          next_state = bthl_pkg::ST_IDLE;
        end
      end
      bthl_pkg::ST_STOP: begin
        if (irqPending) begin
          next_state = bthl_pkg::ST_IDLE;
        end
      end
      default: next_state = bthl_pkg::ST_IDLE;
    endcase
  end

  // State register and handshakes tied to it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= bthl_pkg::ST_IDLE;
      opReady     <= 1'b0;
      standbyWait <= 1'b0;
      standbyStop <= 1'b0;
    end else begin
      state       <= next_state;
      opReady     <= (next_state == bthl_pkg::ST_IDLE);
      standbyWait <= (next_state == bthl_pkg::ST_WAIT);
      standbyStop <= (next_state == bthl_pkg::ST_STOP);
    end
  end

  // Loop registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loopEndAddress     <= `BTHL_ADDR_RESET;
      loopIterationCount <= `BTHL_COUNT_RESET;
      loopBodyAddress    <= `BTHL_ADDR_RESET;
      loopForever        <= 1'b0;
      loopActive         <= 1'b0;
      pendEnd            <= `BTHL_ADDR_RESET;
      pendCount          <= `BTHL_COUNT_RESET;
      pendBody           <= `BTHL_ADDR_RESET;
      pendForever        <= 1'b0;
    end else if (state == bthl_pkg::ST_PUSH_LOOP) begin
      // body address kept for branch back
      loopEndAddress     <= pendEnd;
      loopIterationCount <= pendCount;
      loopBodyAddress    <= pendBody;
      loopForever        <= pendForever;
      loopActive         <= 1'b1;
    end else if (state == bthl_pkg::ST_POP_CTX) begin
      // restore outer body, mode and activity
      loopBodyAddress    <= stackTop[31:16];
      loopForever        <= stackTop[1];
      loopActive         <= stackTop[0];
    end else if (exitStart) begin
      // restore outer end address and count
      loopEndAddress     <= stackTop[31:16];
      loopIterationCount <= stackTop[15:0];
    end else if (startLoop) begin
      pendEnd            <= opReq.endAddress;
      pendBody           <= opReq.bodyAddress;
      pendForever        <= (kind == bthl_pkg::OPK_LOOP_FOREVER_OP);
      pendCount          <= (kind == bthl_pkg::OPK_LOOP_FOREVER_OP) ? 16'h0000 :
                            opReq.iterations;
    end else if (endHit && !loopForever) begin
      loopIterationCount <= loopIterationCount - 16'h0001;
    end
  end

  // redirect decided on the fetch of the end address, or on a taken break or an abort
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loopRedirect    <= 1'b0;
      redirectAddress <= `BTHL_ADDR_RESET;
      loopExit        <= 1'b0;
    end else begin
      loopExit     <= exitStart;
      loopRedirect <= (endHit && !endFinal) || breakHit || abortHit;
      if (breakHit || abortHit) begin
        redirectAddress <= loopEndAddress + 16'h0001;
      end else if (endHit && !endFinal) begin
        redirectAddress <= loopBodyAddress;
      end
    end
  end

  // selected bit kept, set, cleared or inverted
  assign bitMask   = 16'h0001 << opReq.bitSelect;
  assign testedBit = |(opReq.memoryData & bitMask);
  always_comb begin
    case (kind)
      bthl_pkg::OPK_BIT_TEST_INVERT_OP: bitResult = opReq.memoryData ^ bitMask;
      bthl_pkg::OPK_BIT_TEST_ZERO_OP:   bitResult = opReq.memoryData & ~bitMask;
      bthl_pkg::OPK_BIT_TEST_ONE_OP:    bitResult = opReq.memoryData | bitMask;
      default:                          bitResult = opReq.memoryData;
    endcase
  end

  // Write-back and per-operation pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitWriteEnable <= 1'b0;
      bitWriteData   <= 16'h0000;
      opDone         <= 1'b0;
      opReject       <= 1'b0;
      moveDropped    <= 1'b0;
      execStrobe     <= 1'b0;
      periphReset    <= 1'b0;
    end else begin
      bitWriteEnable <= doOp && isBitOp && (kind != bthl_pkg::OPK_BIT_TEST_ONLY_OP);
      if (doOp && isBitOp) begin
        bitWriteData <= bitResult;
      end
      opDone      <= doOp;
      opReject    <= takeOp && rejectOp;
      moveDropped <= doOp && parViolation;
      // operation runs only on a true condition
      execStrobe  <= doOp && opReq.condTrue &&
                     ((kind == bthl_pkg::OPK_COND_EXEC_OP) ||
                      (kind == bthl_pkg::OPK_COND_EXEC_FLAG_UPDATE_OP));
      periphReset <= doOp && (kind == bthl_pkg::OPK_PERIPH_RESET_OP);
    end
  end

  // Condition flags; hardware update wins over a software write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conditionFlagReg <= `BTHL_FLAG_RESET;
    end else if (doOp && isBitOp) begin
      // carry holds the bit before modification
      conditionFlagReg[`BTHL_FLAG_CARRY] <= testedBit;
    end else if (doOp && (kind == bthl_pkg::OPK_MOVE_OP) && opReq.saturated) begin
      // only limit changes on a move
      conditionFlagReg[`BTHL_FLAG_LIMIT] <= 1'b1;
    end else if (doOp && (kind == bthl_pkg::OPK_COND_EXEC_FLAG_UPDATE_OP) &&
                 opReq.condTrue) begin
      conditionFlagReg <= opReq.newFlags;
    end else if (flagSwWrite) begin
      conditionFlagReg <= avsWriteData[7:0];
    end
  end

  // hold the following instruction for its repeat count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      repeatLeft <= 16'h0000;
      repeatHold <= 1'b0;
    end else if (doOp && (kind == bthl_pkg::OPK_REPEAT_NEXT_OP)) begin
      repeatLeft <= opReq.iterations;
      repeatHold <= (opReq.iterations > 16'h0001);
    end else if (doOp && (repeatLeft != 16'h0000)) begin
      repeatLeft <= repeatLeft - 16'h0001;
      repeatHold <= (repeatLeft > 16'h0002);
    end
  end

  // Bus write strobes, taken at the edge with waitrequest low
  assign flagSwWrite = avsWrite && !avsWaitRequest && (avsAddress == `BTHL_OFS_FLAGS);
  assign ctrlSwWrite = avsWrite && !avsWaitRequest && (avsAddress == `BTHL_OFS_CTRL);

  // Control register: refusal mode for parallel moves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rejectMode <= `BTHL_CTRL_RESET;
    end else if (ctrlSwWrite) begin
      rejectMode <= avsWriteData[0];
    end
  end

  // Read data select, unmapped reads as zero
  always_comb begin
    case (avsAddress)
      `BTHL_OFS_STATUS: readMux = {18'h00000, state, 1'b0, stackDepth,
                                   repeatHold, loopForever, loopActive};
      `BTHL_OFS_FLAGS:  readMux = {24'h000000, conditionFlagReg};
      `BTHL_OFS_LOOP:   readMux = {loopEndAddress, loopIterationCount};
      `BTHL_OFS_CTRL:   readMux = {31'h00000000, rejectMode};
      default:          readMux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h0000_0000;
    end else if (avsWaitRequest && (avsRead || avsWrite)) begin
      avsWaitRequest <= 1'b0;
      avsReadData    <= readMux;
    end else begin
      avsWaitRequest <= 1'b1;
    end
  end

  a_carry_tested: assert property (@(posedge clk) disable iff (!rst_b)
    (doOp && isBitOp) |=> (conditionFlagReg[`BTHL_FLAG_CARRY] == $past(testedBit)))
    else $error("carry does not hold tested bit");
  a_bit_modify: assert property (@(posedge clk) disable iff (!rst_b)
    (doOp && (kind == bthl_pkg::OPK_BIT_TEST_ONE_OP)) |=>
    (bitWriteEnable && (bitWriteData == ($past(opReq.memoryData) | $past(bitMask)))))
    else $error("bit set result wrong");
  a_par_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (parViolation && rejectMode) |=> (opReject && !opDone && !bitWriteEnable))
    else $error("parallel move not refused");
  a_loop_push: assert property (@(posedge clk) disable iff (!rst_b)
    startLoop |=> ##1 (loopActive && (stackDepth == $past(stackDepth, 2) + 5'h02)))
    else $error("loop start did not stack two words");
  a_loop_branch: assert property (@(posedge clk) disable iff (!rst_b)
    (endHit && !endFinal && !breakHit && !abortHit) |=>
    (loopRedirect && (redirectAddress == $past(loopBodyAddress))))
    else $error("no branch back at loop end");
  a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
    (endHit && !loopForever && !exitStart) |=>
    (loopIterationCount == $past(loopIterationCount) - 16'h0001))
    else $error("loop count not decremented");
  a_loop_pop: assert property (@(posedge clk) disable iff (!rst_b)
    exitStart |=> (loopExit ##1 (stackDepth == $past(stackDepth, 2) - 5'h02)))
    else $error("loop exit did not pop two words");
  a_move_flags: assert property (@(posedge clk) disable iff (!rst_b)
    (doOp && (kind == bthl_pkg::OPK_MOVE_OP) && !flagSwWrite) |=>
    ((conditionFlagReg & 8'hbf) == ($past(conditionFlagReg) & 8'hbf)))
    else $error("move changed a flag other than limit");
  a_plain_cond: assert property (@(posedge clk) disable iff (!rst_b)
    (doOp && (kind == bthl_pkg::OPK_COND_EXEC_OP) && !flagSwWrite) |=> $stable(conditionFlagReg))
    else $error("plain conditional execute changed flags");
  a_wait_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (standbyWait && !irqPending) |=> (standbyWait && !opReady && !standbyStop))
    else $error("wait standby left without interrupt");
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_b)
    ((avsRead || avsWrite) && avsWaitRequest) |=> !avsWaitRequest)
    else $error("bus access not answered in one cycle");

endmodule : bthl_loop_ctl

// ### hdl/bthl_regs.svh
`ifndef BTHL_REGS_SVH
`define BTHL_REGS_SVH

// Register byte offsets on the slave port
`define BTHL_OFS_STATUS   4'h0
`define BTHL_OFS_FLAGS    4'h4
`define BTHL_OFS_LOOP     4'h8
`define BTHL_OFS_CTRL     4'hc

// Condition flag field positions
`define BTHL_FLAG_CARRY   0
`define BTHL_FLAG_LIMIT   6

// Reset values
`define BTHL_FLAG_RESET   8'h00
`define BTHL_CTRL_RESET   1'b1
`define BTHL_ADDR_RESET   16'h0000
`define BTHL_COUNT_RESET  16'h0000

// System stack geometry
`define BTHL_STACK_WORDS  16
`define BTHL_STACK_WIDTH  32
`define BTHL_STACK_PTR_W  5
`define BTHL_STACK_ROOM   5'h0e

`endif

// ### hdl/bthl_pkg.sv
package bthl_pkg;

  // Decoded operation kinds presented by the sequencer
  typedef enum logic [4:0] {
    OPK_NONE                     = 5'h00,
    OPK_BIT_TEST_INVERT_OP       = 5'h01,
    OPK_BIT_TEST_ZERO_OP         = 5'h02,
    OPK_BIT_TEST_ONE_OP          = 5'h03,
    OPK_BIT_TEST_ONLY_OP         = 5'h04,
    OPK_LOOP_START_OP            = 5'h05,
    OPK_LOOP_FOREVER_OP          = 5'h06,
    OPK_COND_LOOP_BREAK_OP       = 5'h07,
    OPK_LOOP_ABORT_OP            = 5'h08,
    OPK_MOVE_OP                  = 5'h09,
    OPK_REPEAT_NEXT_OP           = 5'h0a,
    OPK_WAIT_OP                  = 5'h0b,
    OPK_STOP_OP                  = 5'h0c,
    OPK_PERIPH_RESET_OP          = 5'h0d,
    OPK_COND_EXEC_OP             = 5'h0e,
    OPK_COND_EXEC_FLAG_UPDATE_OP = 5'h0f,
    OPK_FLOW_OP                  = 5'h10
  } bthl_op_t;

  // One decoded operation with its operands
  typedef struct packed {
    bthl_op_t    kind;
    logic [3:0]  bitSelect;
    logic [15:0] memoryData;
    logic        condTrue;
    logic        parallelMove;
    logic        saturated;
    logic [7:0]  newFlags;
    logic [15:0] iterations;
    logic [15:0] endAddress;
    logic [15:0] bodyAddress;
  } bthl_op_req_t;

  // Controller states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE      = 5'b00001,
    ST_PUSH_LOOP = 5'b00010,
    ST_POP_CTX   = 5'b00100,
    ST_WAIT      = 5'b01000,
    ST_STOP      = 5'b10000
  } bthl_state_t;

endpackage : bthl_pkg

// ### hdl/bthl_sys_stack.sv
`timescale 1ns/1ps
`include "bthl_regs.svh"

module bthl_sys_stack (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  // Stack operations
  input  wire logic                           push,
  input  wire logic                           pop,
  input  wire logic [`BTHL_STACK_WIDTH-1:0]   pushData,
  // Stack state
  output logic      [`BTHL_STACK_WIDTH-1:0]   topData,
  output logic      [`BTHL_STACK_PTR_W-1:0]   depth
);

  logic [`BTHL_STACK_WIDTH-1:0] mem [0:`BTHL_STACK_WORDS-1];
  logic [`BTHL_STACK_PTR_W-1:0] topIndex;

  // Top of stack, zero when empty
  assign topIndex = depth - 5'h01;
  assign topData  = (depth == 5'h00) ? 32'h0000_0000 : mem[topIndex[3:0]];

  // Entry storage
  always_ff @(posedge clk) begin
    if (push && (depth != 5'h10)) begin
      mem[depth[3:0]] <= pushData;
    end
  end

  // Occupancy pointer; push ignored when full, pop when empty
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      depth <= 5'h00;
    end else if (push && !pop && (depth != 5'h10)) begin
      depth <= depth + 5'h01;
    end else if (pop && !push && (depth != 5'h00)) begin
      depth <= depth - 5'h01;
    end
  end

endmodule : bthl_sys_stack

// ### sim/bthl_fetch_model.sv
`timescale 1ns/1ps
module bthl_fetch_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Sequencer fetch stream
  input  wire logic        run,
  input  wire logic [15:0] startAddress,
  input  wire logic        loopRedirect,
  input  wire logic [15:0] redirectAddress,
  output logic             fetchValid,
  output logic [15:0]      fetchAddress,
  output logic [7:0]       nRedirect
);
  // branch back taken on the very next fetch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchValid   <= 1'b0;
      fetchAddress <= 16'hffff;
      nRedirect    <= 8'h00;
    end else begin
      fetchValid <= run;
      if (!run) fetchAddress <= startAddress;
      else if (loopRedirect) fetchAddress <= redirectAddress;
      else fetchAddress <= fetchAddress + 16'h0001;
      if (loopRedirect) nRedirect <= nRedirect + 8'h01;
    end
  end
endmodule : bthl_fetch_model

// ### sim/test_bthl_loop_ctl.sv
`timescale 1ns/1ps
module test_bthl_loop_ctl;
  localparam logic [15:0] END_A = 16'h0012;
  localparam logic [15:0] BODY_A = 16'h0010;
  logic        clk, rst_b, avsRead, avsWrite, avsWaitRequest, opValid, opReady, opDone;
  logic        opReject, moveDropped, fetchValid, loopRedirect, loopExit, loopActive;
  logic        bitWriteEnable, execStrobe, repeatHold, irqPending, standbyWait, standbyStop;
  logic        periphReset, run;
  logic [3:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [15:0] fetchAddress, redirectAddress, bitWriteData, ex, m;
  logic [7:0]  conditionFlagReg, nRedirect, g;
  bthl_pkg::bthl_op_req_t opReq;
  bthl_pkg::bthl_op_t     k;
  int          n_mismatch, n_compared, cyc;
  bthl_loop_ctl dut_u (.clk, .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsReadData, .avsWaitRequest, .opValid, .opReq, .opReady, .opDone, .opReject,
    .moveDropped, .fetchValid, .fetchAddress, .loopRedirect, .redirectAddress, .loopExit,
    .loopActive, .bitWriteEnable, .bitWriteData, .conditionFlagReg, .execStrobe,
    .repeatHold, .irqPending, .standbyWait, .standbyStop, .periphReset);
  bthl_fetch_model fm_u (.clk, .rst_b, .run, .startAddress(BODY_A), .loopRedirect,
    .redirectAddress, .fetchValid, .fetchAddress, .nRedirect);
  // Clock and hang guard
  initial begin clk = 0; forever #2 clk = ~clk; end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin n_mismatch++; final_report(); end
  end
  task final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk); avsAddress <= a; avsWrite <= w; avsRead <= !w; avsWriteData <= d;
    @(posedge clk);
    while (avsWaitRequest !== 1'b0) @(posedge clk);
    q = avsReadData;
    avsRead <= 1'b0; avsWrite <= 1'b0;
  endtask : bus
  // One operation; g = {done, reject, dropped, write, exec, periph, wait, exit}
  task op(input bthl_pkg::bthl_op_t kk, input logic [3:0] s, input logic [15:0] mm,
          input logic c, input logic p, input logic t, input logic [7:0] f);
    @(posedge clk); opValid <= 1'b1;
    opReq <= '{kk, s, mm, c, p, t, f, 16'h0003, END_A, BODY_A};
    #1; while (opReady !== 1'b1) begin @(posedge clk); #1; end
    @(posedge clk); opValid <= 1'b0; #1;
    g = {opDone, opReject, moveDropped, bitWriteEnable, execStrobe, periphReset,
         standbyWait, loopExit};
  endtask : op
  initial begin
    {avsRead, avsWrite, opValid, irqPending, run, rst_b} = '0;
    {avsAddress, avsWriteData, opReq, n_mismatch, n_compared, cyc} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 4'h4, 0); chk(q, 0);
    bus(0, 4'h2, 0); chk(q, 0);
    m = 16'h0012;
    // Every bit operation on a set and a clear bit
    for (int i = 1; i < 5; i++) for (int s = 1; s >= 0; s--) begin
      k = bthl_pkg::bthl_op_t'(i);
      ex = (k == bthl_pkg::OPK_BIT_TEST_INVERT_OP) ? m ^ (16'h1 << s) :
           (k == bthl_pkg::OPK_BIT_TEST_ZERO_OP) ? m & ~(16'h1 << s) : m | (16'h1 << s);
      op(k, s[3:0], m, 0, 0, 0, 0);
      chk(g[7], 1);
      if (k != bthl_pkg::OPK_BIT_TEST_ONLY_OP) chk(bitWriteData, ex);
      chk(conditionFlagReg[0], m[s]);
    end
    op(bthl_pkg::OPK_MOVE_OP, 0, 0, 0, 1, 1, 0); chk(conditionFlagReg, 8'h40);
    op(bthl_pkg::OPK_BIT_TEST_ONE_OP, 0, m, 0, 1, 0, 0); chk(g, 8'h40);
    op(bthl_pkg::OPK_LOOP_START_OP, 0, 0, 0, 1, 0, 0); chk(g, 8'h40);
    op(bthl_pkg::OPK_WAIT_OP, 0, 0, 0, 1, 0, 0); chk(g, 8'h40);
    op(bthl_pkg::OPK_LOOP_ABORT_OP, 0, 0, 0, 0, 0, 0); chk(g, 8'h40);
    op(bthl_pkg::OPK_COND_EXEC_OP, 0, 0, 1, 0, 0, 8'h0f); chk(conditionFlagReg, 8'h40);
    op(bthl_pkg::OPK_COND_EXEC_FLAG_UPDATE_OP, 0, 0, 1, 0, 0, 8'h0f); chk(g, 8'h88);
    chk(conditionFlagReg, 8'h0f);
    op(bthl_pkg::OPK_PERIPH_RESET_OP, 0, 0, 0, 0, 0, 0); chk(g, 8'h84);
    bus(0, 4'h4, 0); chk(q, 32'h0f);
    op(bthl_pkg::OPK_WAIT_OP, 0, 0, 0, 0, 0, 0); chk(standbyWait, 1);
    @(posedge clk); irqPending <= 1'b1; repeat (3) @(posedge clk); irqPending <= 1'b0;
    #1; chk(standbyWait, 0);
    op(bthl_pkg::OPK_STOP_OP, 0, 0, 0, 0, 0, 0); chk({standbyStop, standbyWait}, 2'b10);
    @(posedge clk); irqPending <= 1'b1; repeat (3) @(posedge clk); irqPending <= 1'b0;
    #1; chk(standbyStop, 0);
    bus(1, 4'hc, 0);
    bus(0, 4'hc, 0); chk(q, 0);
    op(bthl_pkg::OPK_BIT_TEST_ONE_OP, 0, m, 0, 1, 0, 0); chk(g, 8'hb0);
    // Counted loop of three passes over the fetch model
    op(bthl_pkg::OPK_LOOP_START_OP, 0, 0, 0, 0, 0, 0); repeat (2) @(posedge clk);
    bus(0, 4'h0, 0); chk(q, 32'h211);
    bus(0, 4'h8, 0); chk(q, {END_A, 16'h0003});
    run <= 1'b1;
    for (int i = 0; i < 40 && loopExit !== 1'b1; i++) @(posedge clk);
    run <= 1'b0;
    chk(nRedirect, 2); chk(redirectAddress, BODY_A);
    bus(0, 4'h0, 0); chk(q, 32'h200);
    bus(0, 4'h8, 0); chk(q, 0);
    // Forever loop left by break and by abort
    op(bthl_pkg::OPK_LOOP_FOREVER_OP, 0, 0, 0, 0, 0, 0); repeat (2) @(posedge clk);
    op(bthl_pkg::OPK_COND_LOOP_BREAK_OP, 0, 0, 0, 0, 0, 0); chk(loopActive, 1);
    op(bthl_pkg::OPK_LOOP_ABORT_OP, 0, 0, 0, 0, 0, 0); repeat (3) @(posedge clk);
    chk({loopActive, redirectAddress}, {1'b0, END_A + 16'h1});
    op(bthl_pkg::OPK_LOOP_FOREVER_OP, 0, 0, 0, 0, 0, 0); repeat (2) @(posedge clk);
    op(bthl_pkg::OPK_COND_LOOP_BREAK_OP, 0, 0, 1, 0, 0, 0); repeat (3) @(posedge clk);
    chk(loopActive, 0);
    // Repeat of three: held while the first two copies are taken
    op(bthl_pkg::OPK_REPEAT_NEXT_OP, 0, 0, 0, 0, 0, 0); chk(repeatHold, 1);
    op(bthl_pkg::OPK_COND_EXEC_OP, 0, 0, 0, 0, 0, 0); chk(repeatHold, 1);
    op(bthl_pkg::OPK_COND_EXEC_OP, 0, 0, 0, 0, 0, 0); chk(repeatHold, 0);
    op(bthl_pkg::OPK_COND_EXEC_OP, 0, 0, 0, 0, 0, 0); chk(g, 8'h80);
    final_report();
  end
endmodule : test_bthl_loop_ctl
